//--- dv/cmr_host_model.sv
/*
  Two-wire host controller model for the compass bench: framed byte
  writes and reads with a 48 ns link clock that idles high between frames.
  Assumes a pulled-up data wire whose resolved level comes back on sda_i.
*/
`timescale 1ns/1ps
`default_nettype none
module cmr_host_model (
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_pull_o
);
  initial begin
    scl_o      = 1'b1;
    sda_pull_o = 1'b0;
  end

  // Data moves only while the clock is low, 6 ns after its fall and before the device's change.
  task automatic bit_io(input logic b, output logic r);
    #6 sda_pull_o = ~b;
    #18 scl_o = 1'b1;
    #12 r = sda_i;
    #12 scl_o = 1'b0;
  endtask

  task automatic frame(input logic [7:0] ad, input logic [23:0] wd,
                       input int n, output logic [47:0] rd,
                       output logic ok);
    logic       r;
    logic [7:0] b;
    logic [23:0] w;
    w  = wd;
    ok = 1'b1;
    rd = '0;
    #24 sda_pull_o = 1'b1;
    #24 scl_o = 1'b0;
    for (int i = 0; i < 8; i++) bit_io(ad[7-i], r);
    bit_io(1'b1, r);
    if (r !== 1'b0) ok = 1'b0;
    for (int k = 0; k < n; k++) begin
      b = w[23:16];
      w = w << 8;
      for (int i = 0; i < 8; i++) begin
        bit_io(ad[0] | b[7-i], r);
        b[7-i] = r;
      end
      bit_io(ad[0] ? (k == n - 1) : 1'b1, r);
      if (!ad[0] && r !== 1'b0) ok = 1'b0;
      rd = {rd[39:0], b};
    end
    #6 sda_pull_o = 1'b1;
    #18 scl_o = 1'b1;
    #24 sda_pull_o = 1'b0;
    #48;
  endtask
endmodule
`default_nettype wire

//--- dv/compass_mode_and_readout_tb.sv
/*
  Self-checking bench for the compass mode and readout block: the host
  model drives the link, a small front end answers sample requests.
  Assumes shortened rate counts and host waits so the run stays short.
*/
`timescale 1ns/1ps
`default_nettype none
module compass_mode_and_readout_tb;
  import cmr_pkg::*;
  localparam int WAIT_CYC = 100;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic scl, pull, sda_oe, sda_d, req, fe_en = 1'b1;
  logic [1:0]  pend = 2'b00;
  logic [15:0] head = 16'h0, pitch = 16'h0, roll = 16'h0;
  logic [47:0] mag = '0, off;
  int vcount = 0, bad_count = 0, n_tests = 0;
  wire logic sda_w;
  // The device's driven value counts, so a wrong level breaks every ack.
  assign sda_w = ~pull & (~sda_oe | sda_d);

  always #2.5 clk_i = ~clk_i;

  cmr_compass #(.CYC_1HZ(200), .CYC_5HZ(40), .CYC_10HZ(20)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_d), .sda_oe_o(sda_oe), .sample_req_o(req),
    .sample_valid_i(pend[1]), .head_raw_i(head), .pitch_raw_i(pitch),
    .roll_raw_i(roll), .mag_i(mag), .mag_offset_o(off));

  cmr_host_model host_u (.sda_i(sda_w), .scl_o(scl), .sda_pull_o(pull));

  // Front end answers two cycles after a request, only while enabled.
  always @(posedge clk_i) begin
    pend <= #1 {pend[0], req & fe_en};
    if (pend[1] === 1'b1) vcount <= vcount + 1;
  end

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input logic hit);
    if (hit) begin
      bad_count++;
      $display("[ERR] %0t wait ran out", $time);
      report_and_stop;
    end
  endtask

  task automatic cmd(input logic [23:0] w, input int n);
    logic [47:0] d;
    logic        ok;
    host_u.frame({CMR_DEV_ADDR, 1'b0}, w, n, d, ok);
    chk(ok, 1'b1);
    repeat (WAIT_CYC) @(posedge clk_i);
    #1;
  endtask

  task automatic rd(input int n, output logic [47:0] d);
    logic ok;
    host_u.frame({CMR_DEV_ADDR, 1'b1}, 24'h0, n, d, ok);
    chk(ok, 1'b1);
    @(posedge clk_i);
    #1;
  endtask

  task automatic ee_rd(input logic [7:0] a, output logic [7:0] v);
    logic [47:0] d;
    cmd({CMR_CMD_EE_RD, a, 8'h00}, 2);
    rd(1, d);
    v = d[7:0];
  endtask

  task automatic mode1(output logic [7:0] v);
    logic [47:0] d;
    cmd({CMR_CMD_STATUS, 16'h0}, 1);
    rd(1, d);
    v = d[7:0];
  endtask

  task automatic period(output int p);
    for (int k = 0; k < 2; k++) begin
      p = 0;
      do begin
        @(posedge clk_i);
        #1;
        p++;
      end while (req !== 1'b1 && p < 1000);
      tmo(p >= 1000);
    end
  endtask

  task automatic allow(input int n);
    int t;
    int v0;
    v0 = vcount;
    t = 0;
    fe_en = 1'b1;
    while (vcount < v0 + n && t < 2000) begin
      @(posedge clk_i);
      #1;
      t++;
    end
    fe_en = 1'b0;
    tmo(t >= 2000);
  endtask

  task automatic t_defaults;
    logic [7:0] v;
    ee_rd(CMR_EE_MODE1, v);
    chk(v & 8'h7f, 8'h11);
    ee_rd(CMR_EE_MODE2, v);
    chk(v, 8'h01);
  endtask

  task automatic t_rate;
    logic [7:0] rv [4] = '{8'h00, 8'h02, 8'h03, 8'h01};
    logic [7:0] rb [4] = '{8'h00, 8'h02, 8'h02, 8'h01};
    int         pv [4] = '{200, 20, 20, 40};
    logic [7:0] v;
    int         p;
    for (int i = 0; i < 4; i++) begin
      cmd({CMR_CMD_EE_WR, CMR_EE_MODE2, rv[i]}, 3);
      period(p);
      chk(p, pv[i]);
      ee_rd(CMR_EE_MODE2, v);
      chk(v, rb[i]);
    end
  endtask

  task automatic t_modes;
    logic [7:0] oc [3] = '{CMR_CMD_EDGE, CMR_CMD_FRONT, CMR_CMD_LEVEL};
    logic [2:0] oe [3] = '{CMR_OR_EDGE, CMR_OR_FRONT, CMR_OR_LEVEL};
    logic [7:0] v;
    int         p;
    int         c;
    for (int i = 0; i < 3; i++) begin
      cmd({oc[i], 16'h0}, 1);
      mode1(v);
      chk(v[2:0], oe[i]);
    end
    cmd({CMR_CMD_EE_WR, CMR_EE_MODE1, 8'h13}, 3);
    mode1(v);
    chk(v & 8'h7f, 8'h11);
    cmd({CMR_CMD_STBY, 16'h0}, 1);
    mode1(v);
    chk(v[4:3], 2'b01);
    c = 0;
    repeat (300) begin
      @(posedge clk_i);
      #1;
      if (req !== 1'b0) c++;
    end
    chk(c, 0);
    cmd({CMR_CMD_RUN, 16'h0}, 1);
    mode1(v);
    chk(v[4:3], 2'b10);
    period(p);
    chk(p, 40);
  endtask

  task automatic t_head;
    logic [47:0] d;
    logic [7:0]  v;
    int          p;
    head  = 16'd3605;
    pitch = -16'sd950;
    roll  = 16'd123;
    allow(1);
    cmd({CMR_CMD_HEADING, 16'h0}, 1);
    rd(6, d);
    chk(d, {16'h0e10, 16'hfc7c, 16'h007b});
    period(p);
    mode1(v);
    chk(v[7], 1'b1);
    cmd({CMR_CMD_EE_WR, CMR_EE_MODE1, 8'h31}, 3);
    mode1(v);
    chk(v & 8'h7f, 8'h31);
    head = 16'h0;
    allow(1);
    cmd({CMR_CMD_HEADING, 16'h0}, 1);
    rd(6, d);
    chk(d, {16'h0a8c, 16'hfc7c, 16'h007b});
  endtask

  task automatic t_cal;
    mag = {16'h0032, 16'hffec, 16'h0064};
    cmd({CMR_CMD_CAL_IN, 16'h0}, 1);
    allow(2);
    mag = {16'hfff6, 16'h003c, 16'hfed4};
    allow(2);
    chk(off, 48'h0);
    cmd({CMR_CMD_CAL_OUT, 16'h0}, 1);
    chk(off, {16'h0014, 16'h0014, 16'hff9c});
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    repeat (WAIT_CYC) @(posedge clk_i);
    #1;
    t_defaults;
    t_rate;
    t_modes;
    t_head;
    t_cal;
    report_and_stop;
  end
endmodule
`default_nettype wire

//--- hdl/cmr_compass.sv
/*
  Mode and readout logic of a tilt-compensated compass: mode registers,
  command decode, measurement pacing, heading filter, hard-iron calibration
  and the two-wire slave that returns heading, pitch and roll.
  Assumes the host paces commands with the documented waits and that the
  sensor front end answers each sample request one or more clocks later.
*/
// Notes on behaviour
// - Mode register bit 7 is high while a heading computation runs.
// - Mode register bit 6 is high while calibration offsets are computed.
// - Bit 5 set passes heading through an IIR smoothing filter.
// - Bit 4 shows continuous measuring, bit 3 shows standby.
// - Bits 2..0 select front, edge or level mounting orientation.
// - Rate field: 00 is 1 Hz, 01 is 5 Hz default, 10 is 10 Hz.
// - Command 0x71 enters user calibration, 0x7e leaves it.
// - In calibration magnetometer readings are gathered for hard-iron use.
// - Leaving calibration after one or more readings replaces the stored offsets with new values.
// - After initialisation the device measures continuously unasked.
// - Read address 0x33 returns six bytes, pairs most significant first.
// - Angles in tenths: heading 0..3600, pitch and roll within 900.
// - Mode registers sit at memory locations 0x04 and 0x05.
// - 0x75 goes standby to run, 0x76 run to standby.
`timescale 1ns/1ps
`default_nettype none
module cmr_compass
  import cmr_pkg::*;
#(
  parameter int CYC_1HZ  = CMR_CLK_HZ / CMR_HZ_1,
  parameter int CYC_5HZ  = CMR_CLK_HZ / CMR_HZ_5,
  parameter int CYC_10HZ = CMR_CLK_HZ / CMR_HZ_10
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             sample_req_o,
  input  wire logic        sample_valid_i,
  input  wire logic [15:0] head_raw_i,
  input  wire logic [15:0] pitch_raw_i,
  input  wire logic [15:0] roll_raw_i,
  input  wire logic [47:0] mag_i,
  output logic      [47:0] mag_offset_o
);
  logic [2:0] scl_sync, sda_sync;
  logic       scl_rise, scl_fall, start_det, stop_det;
  cmr_link_e  st_reg;
  logic [3:0] bit_reg;
  logic [7:0] rx_reg, tx_reg;
  logic [1:0] wr_idx_reg, byte_pos_reg;
  logic       byte_stb_reg;
  logic [7:0] byte_reg;
  logic [2:0] rd_idx_reg;
  logic [7:0] resp_reg [CMR_RESP_BYTES];
  logic [7:0] cmd_reg, ee_addr_reg;
  logic       comp_reg, cal_busy_reg, cal_mode_reg, filt_reg;
  logic       run_reg, stby_reg, cal_first_reg;
  logic [2:0] orient_reg;
  logic [1:0] rate_reg;
  logic [31:0] rate_cnt_reg, rate_per;
  logic [7:0] mode1, mode2;
  logic signed [16:0] head_reg, pitch_reg, roll_reg, head_c, diff;

  // Only the second stage and later ever feed logic.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
    end
  end
  assign scl_rise  = scl_sync[1] & ~scl_sync[2];
  assign scl_fall  = ~scl_sync[1] & scl_sync[2];
  assign start_det = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
  assign stop_det  = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];

  assign mode1 = {comp_reg, cal_busy_reg, filt_reg, run_reg, stby_reg,
                  orient_reg};
  assign mode2 = {6'h00, rate_reg};

  // Open-drain slave: the pin is only ever pulled low.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_reg       <= CMR_IDLE;
      bit_reg      <= 4'h0;
      rx_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      sda_oe_o     <= 1'b0;
      sda_o        <= 1'b0;
      wr_idx_reg   <= 2'h0;
      byte_pos_reg <= 2'h0;
      byte_stb_reg <= 1'b0;
      byte_reg     <= 8'h00;
      rd_idx_reg   <= 3'h0;
    end else begin
      byte_stb_reg <= 1'b0;
      if (start_det) begin
        st_reg     <= CMR_ADDR;
        // All ones, so the start's own clock fall wraps it to bit zero.
        bit_reg    <= '1;
        wr_idx_reg <= 2'h0;
        sda_oe_o   <= 1'b0;
      end else if (stop_det) begin
        st_reg   <= CMR_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise && st_reg != CMR_IDLE) begin
        if (bit_reg == CMR_BIT_ACK) begin
          if (st_reg == CMR_RD && sda_sync[1]) begin
            st_reg <= CMR_NAK;
          end
        end else begin
          rx_reg <= {rx_reg[6:0], sda_sync[1]};
        end
      end else if (scl_fall && st_reg != CMR_IDLE && st_reg != CMR_NAK) begin
        if (bit_reg == CMR_BIT_LAST) begin
          bit_reg <= CMR_BIT_ACK;
          case (st_reg)
            CMR_ADDR: begin
              if (rx_reg[7:1] == CMR_DEV_ADDR) begin
                sda_oe_o   <= 1'b1;
                rd_idx_reg <= 3'h0;
                st_reg     <= rx_reg[0] ? CMR_RD : CMR_WR;
              end else begin
                st_reg <= CMR_NAK;
              end
            end
            CMR_WR: begin
              sda_oe_o     <= 1'b1;
              byte_stb_reg <= 1'b1;
              byte_reg     <= rx_reg;
              byte_pos_reg <= wr_idx_reg;
              if (wr_idx_reg != CMR_WR_SAT) begin
                wr_idx_reg <= wr_idx_reg + 2'h1;
              end
            end
            default: sda_oe_o <= 1'b0;
          endcase
        end else if (bit_reg == CMR_BIT_ACK) begin
          bit_reg <= 4'h0;
          if (st_reg == CMR_RD) begin
            tx_reg     <= (rd_idx_reg < 3'(CMR_RESP_BYTES)) ?
                          resp_reg[rd_idx_reg] : 8'h00;
            sda_oe_o   <= (rd_idx_reg < 3'(CMR_RESP_BYTES)) ?
                          ~resp_reg[rd_idx_reg][7] : 1'b1;
            rd_idx_reg <= rd_idx_reg + 3'h1;
          end else begin
            sda_oe_o <= 1'b0;
          end
        end else begin
          bit_reg <= bit_reg + 4'h1;
          if (st_reg == CMR_RD) begin
            tx_reg   <= {tx_reg[6:0], 1'b0};
            sda_oe_o <= ~tx_reg[6];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_reg     <= 8'h00;
      ee_addr_reg <= 8'h00;
    end else if (byte_stb_reg) begin
      if (byte_pos_reg == 2'h0) begin
        cmd_reg <= byte_reg;
      end else if (byte_pos_reg == 2'h1) begin
        ee_addr_reg <= byte_reg;
      end
    end
  end

  // A single run or standby bit is kept by construction.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      run_reg    <= 1'b1;
      stby_reg   <= 1'b0;
      orient_reg <= CMR_OR_LEVEL;
      filt_reg   <= 1'b0;
      rate_reg   <= CMR_RATE_5HZ;
    end else if (byte_stb_reg && byte_pos_reg == 2'h0) begin
      case (byte_reg)
        CMR_CMD_RUN:   begin run_reg <= 1'b1; stby_reg <= 1'b0; end
        CMR_CMD_STBY:  begin run_reg <= 1'b0; stby_reg <= 1'b1; end
        CMR_CMD_LEVEL: orient_reg <= CMR_OR_LEVEL;
        CMR_CMD_EDGE:  orient_reg <= CMR_OR_EDGE;
        CMR_CMD_FRONT: orient_reg <= CMR_OR_FRONT;
        default: ;
      endcase
    end else if (byte_stb_reg && byte_pos_reg == 2'h2 &&
                 cmd_reg == CMR_CMD_EE_WR) begin
      if (ee_addr_reg == CMR_EE_MODE1) begin
        filt_reg <= byte_reg[CMR_B_FILT];
        // Malformed patterns are dropped so the bits stay one-hot.
        if ($onehot(byte_reg[2:0])) begin
          orient_reg <= byte_reg[2:0];
        end
        if (byte_reg[CMR_B_RUN] != byte_reg[CMR_B_STBY]) begin
          run_reg  <= byte_reg[CMR_B_RUN];
          stby_reg <= byte_reg[CMR_B_STBY];
        end
      end else if (ee_addr_reg == CMR_EE_MODE2 &&
                   byte_reg[1:0] != CMR_RATE_NONE) begin
        rate_reg <= byte_reg[1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < CMR_RESP_BYTES; i++) resp_reg[i] <= 8'h00;
    end else if (byte_stb_reg && byte_pos_reg == 2'h0 &&
                 byte_reg == CMR_CMD_HEADING) begin
      resp_reg[0] <= head_reg[15:8];
      resp_reg[1] <= head_reg[7:0];
      resp_reg[2] <= pitch_reg[15:8];
      resp_reg[3] <= pitch_reg[7:0];
      resp_reg[4] <= roll_reg[15:8];
      resp_reg[5] <= roll_reg[7:0];
    end else if (byte_stb_reg && byte_pos_reg == 2'h0 &&
                 byte_reg == CMR_CMD_STATUS) begin
      for (int i = 0; i < CMR_RESP_BYTES; i++) resp_reg[i] <= 8'h00;
      resp_reg[0] <= mode1;
    end else if (byte_stb_reg && byte_pos_reg == 2'h1 &&
                 cmd_reg == CMR_CMD_EE_RD) begin
      for (int i = 0; i < CMR_RESP_BYTES; i++) resp_reg[i] <= 8'h00;
      resp_reg[0] <= (byte_reg == CMR_EE_MODE1) ? mode1 :
                     (byte_reg == CMR_EE_MODE2) ? mode2 : 8'h00;
    end
  end

  always_comb begin
    case (rate_reg)
      CMR_RATE_1HZ:  rate_per = 32'(CYC_1HZ);
      CMR_RATE_10HZ: rate_per = 32'(CYC_10HZ);
      default:       rate_per = 32'(CYC_5HZ);
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rate_cnt_reg <= 32'h0;
      sample_req_o <= 1'b0;
    end else begin
      sample_req_o <= 1'b0;
      if (rate_cnt_reg >= rate_per - 32'h1) begin
        rate_cnt_reg <= 32'h0;
        sample_req_o <= run_reg;
      end else begin
        rate_cnt_reg <= rate_cnt_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      comp_reg <= 1'b0;
    end else if (sample_req_o) begin
      comp_reg <= 1'b1;
    end else if (sample_valid_i) begin
      comp_reg <= 1'b0;
    end
  end

  always_comb begin
    head_c = {head_raw_i[15], head_raw_i};
    if (head_c < 17'sh0) head_c = 17'sh0;
    if (head_c > CMR_HEAD_MAX) head_c = CMR_HEAD_MAX;
    diff = head_c - head_reg;
  end

  function automatic logic signed [16:0] tilt(input logic [15:0] v);
    logic signed [16:0] s;
    s = {v[15], v};
    if (s > CMR_TILT_MAX) s = CMR_TILT_MAX;
    if (s < CMR_TILT_MIN) s = CMR_TILT_MIN;
    return s;
  endfunction

  // The filter trades response time for noise; a quarter step per sample.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      head_reg  <= 17'sh0;
      pitch_reg <= 17'sh0;
      roll_reg  <= 17'sh0;
    end else if (sample_valid_i && comp_reg) begin
      head_reg  <= filt_reg ? head_reg + (diff >>> CMR_FILT_SHIFT)
                            : head_c;
      pitch_reg <= tilt(pitch_raw_i);
      roll_reg  <= tilt(roll_raw_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cal_mode_reg <= 1'b0;
      cal_busy_reg <= 1'b0;
    end else begin
      cal_busy_reg <= 1'b0;
      if (byte_stb_reg && byte_pos_reg == 2'h0) begin
        if (byte_reg == CMR_CMD_CAL_IN) begin
          cal_mode_reg <= 1'b1;
        end else if (byte_reg == CMR_CMD_CAL_OUT && cal_mode_reg) begin
          cal_mode_reg <= 1'b0;
          cal_busy_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || (byte_stb_reg && byte_reg == CMR_CMD_CAL_IN &&
                      byte_pos_reg == 2'h0)) begin
      cal_first_reg <= 1'b1;
    end else if (sample_valid_i && cal_mode_reg) begin
      cal_first_reg <= 1'b0;
    end
  end

  // Hard-iron offset per axis is the centre of the seen min and max.
  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic signed [15:0] mn_reg, mx_reg, smp;
    logic signed [16:0] sum;
    logic        [15:0] off_reg;
    assign smp = mag_i[16*a +: 16];
    assign sum = 17'(mn_reg) + 17'(mx_reg);
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        mn_reg <= 16'sh0;
        mx_reg <= 16'sh0;
      end else if (sample_valid_i && cal_mode_reg) begin
        mn_reg <= (cal_first_reg || smp < mn_reg) ? smp : mn_reg;
        mx_reg <= (cal_first_reg || smp > mx_reg) ? smp : mx_reg;
      end
    end
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        off_reg <= 16'h0;
      end else if (cal_busy_reg && !cal_first_reg) begin
        off_reg <= sum[16:1];
      end
    end
  end
  // One driver for the whole output keeps the axes from splitting it.
  assign mag_offset_o = {g_axis[2].off_reg, g_axis[1].off_reg,
                         g_axis[0].off_reg};

  sequence s_exit_cal;
    byte_stb_reg && byte_pos_reg == 2'h0 && byte_reg == CMR_CMD_CAL_OUT &&
    cal_mode_reg;
  endsequence
  sequence s_busy_then_free;
    cal_busy_reg ##1 !cal_busy_reg;
  endsequence

  property p_comp_flag;
    @(posedge clk_i) disable iff (sys_rst_i)
    sample_req_o && !sample_valid_i |=> mode1[CMR_B_COMP];
  endproperty
  a_comp_flag: assert property (p_comp_flag)
    else $error("computing flag not raised after sample request");

  property p_cal_flag;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_exit_cal |=> mode1[CMR_B_CAL] ##0 s_busy_then_free;
  endproperty
  a_cal_flag: assert property (p_cal_flag)
    else $error("calibration flag not a one-cycle pulse after exit");

  property p_filter_off;
    @(posedge clk_i) disable iff (sys_rst_i)
    sample_valid_i && comp_reg && !filt_reg |=> head_reg == $past(head_c);
  endproperty
  a_filter_off: assert property (p_filter_off)
    else $error("unfiltered heading differs from clamped input");

  property p_orient;
    @(posedge clk_i) disable iff (sys_rst_i)
    $onehot(orient_reg) && (run_reg ^ stby_reg);
  endproperty
  a_orient: assert property (p_orient)
    else $error("orientation or run state not one-hot");

  property p_rate_up;
    @(posedge clk_i) disable iff (sys_rst_i)
    mode2[7:2] == 6'h00 && rate_reg != CMR_RATE_NONE;
  endproperty
  a_rate_up: assert property (p_rate_up)
    else $error("rate register holds an unassigned value");

  property p_cal_enter;
    @(posedge clk_i) disable iff (sys_rst_i)
    byte_stb_reg && byte_pos_reg == 2'h0 && byte_reg == CMR_CMD_CAL_IN
      |=> cal_mode_reg ##1 (cal_first_reg || !sample_valid_i);
  endproperty
  a_cal_enter: assert property (p_cal_enter)
    else $error("calibration mode not entered on command");

  property p_run_reset;
    @(posedge clk_i) $fell(sys_rst_i) |-> run_reg && !stby_reg;
  endproperty
  a_run_reset: assert property (p_run_reset)
    else $error("device not measuring after reset");

  property p_range;
    @(posedge clk_i) disable iff (sys_rst_i)
    head_reg >= 17'sh0 && head_reg <= CMR_HEAD_MAX &&
    pitch_reg <= CMR_TILT_MAX && pitch_reg >= CMR_TILT_MIN &&
    roll_reg <= CMR_TILT_MAX && roll_reg >= CMR_TILT_MIN;
  endproperty
  a_range: assert property (p_range)
    else $error("angle outside its range");

  property p_standby_quiet;
    @(posedge clk_i) disable iff (sys_rst_i)
    stby_reg && $stable(stby_reg) |-> !sample_req_o;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet)
    else $error("sample requested in standby");
endmodule
`default_nettype wire

//--- hdl/cmr_pkg.sv
/*
  Constants shared by the compass mode and readout block: link address,
  command codes, mode register layout, reset values, angle limits and rates.
  Assumes a 200 MHz system clock and a 7-bit two-wire link address.
*/
package cmr_pkg;
  localparam logic [6:0] CMR_DEV_ADDR    = 7'h19;
  localparam logic [7:0] CMR_CMD_HEADING = 8'h50;
  localparam logic [7:0] CMR_CMD_STATUS  = 8'h65;
  localparam logic [7:0] CMR_CMD_CAL_IN  = 8'h71;
  localparam logic [7:0] CMR_CMD_LEVEL   = 8'h72;
  localparam logic [7:0] CMR_CMD_EDGE    = 8'h73;
  localparam logic [7:0] CMR_CMD_FRONT   = 8'h74;
  localparam logic [7:0] CMR_CMD_RUN     = 8'h75;
  localparam logic [7:0] CMR_CMD_STBY    = 8'h76;
  localparam logic [7:0] CMR_CMD_CAL_OUT = 8'h7e;
  localparam logic [7:0] CMR_CMD_EE_RD   = 8'he1;
  localparam logic [7:0] CMR_CMD_EE_WR   = 8'hf1;
  localparam logic [7:0] CMR_EE_MODE1    = 8'h04;
  localparam logic [7:0] CMR_EE_MODE2    = 8'h05;
  localparam int CMR_B_COMP   = 7;
  localparam int CMR_B_CAL    = 6;
  localparam int CMR_B_FILT   = 5;
  localparam int CMR_B_RUN    = 4;
  localparam int CMR_B_STBY   = 3;
  localparam logic [2:0] CMR_OR_FRONT = 3'h4;
  localparam logic [2:0] CMR_OR_EDGE  = 3'h2;
  localparam logic [2:0] CMR_OR_LEVEL = 3'h1;
  localparam logic [1:0] CMR_RATE_1HZ  = 2'h0;
  localparam logic [1:0] CMR_RATE_5HZ  = 2'h1;
  localparam logic [1:0] CMR_RATE_10HZ = 2'h2;
  localparam logic [1:0] CMR_RATE_NONE = 2'h3;
  localparam int CMR_CLK_HZ = 200_000_000;
  localparam int CMR_HZ_1   = 1;
  localparam int CMR_HZ_5   = 5;
  localparam int CMR_HZ_10  = 10;
  localparam logic signed [16:0] CMR_HEAD_MAX = 17'sh00e10;
  localparam logic signed [16:0] CMR_TILT_MAX = 17'sh00384;
  localparam logic signed [16:0] CMR_TILT_MIN = -17'sh00384;
  localparam int CMR_RESP_BYTES = 6;
  localparam int CMR_FILT_SHIFT = 2;
  localparam logic [1:0] CMR_WR_SAT = 2'h3;
  localparam logic [3:0] CMR_BIT_LAST = 4'h7;
  localparam logic [3:0] CMR_BIT_ACK  = 4'h8;
  typedef enum logic [2:0] {
    CMR_IDLE, CMR_ADDR, CMR_WR, CMR_RD, CMR_NAK
  } cmr_link_e;
endpackage
